// *** logic/drive_status_output_logic.sv ***
// Notes on behaviour
// - Wear warning rises when any wear quantity hits its level; no trip, fault relay untouched.
// - Main capacitor worn once measured value is 85 percent or less of reference.
// - Board capacitor worn after 61000 hours; cooling fan after 25000 running hours.
// - On large units a broken stirring fan also raises the wear warning.
// - Main capacitor judgement can be disabled when it would be unreliable.
// - Second level detector uses its own level and the shared hysteresis.
// - Second current warning when current exceeds its level longer than the timer.
// - Loop loss output while analogue current input is below 2 mA.
// - Delayed limiting flag after any limiting action holds 20 ms or more.
// - Factory selection codes for five outputs are 0, 1, 2, 7 and 10.
// - Relay polarity 0 closes contact on signal on; 1 closes on signal off.
// - Inverted relay closes only once control voltage is established.
// - Arrival output while output frequency lies within band of set frequency, 0-10 Hz.
// - Level output sets when output frequency exceeds the operation level.
// - Level limited to 400 or 120 Hz by model; hysteresis to 30 Hz.
`timescale 1ns/100ps
`default_nettype none
module drive_status_output_logic #(
  parameter longint LIMIT_CYCLES = status_out_pkg::LIMIT_DELAY_CYCLES,
  parameter longint MS_CYCLES = status_out_pkg::CYCLES_PER_MS,
  parameter longint HOUR_MS = status_out_pkg::MS_PER_HOUR
) (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire status_out_pkg::drive_in_s drive_in, // Drive quantities
  input wire logic ctrl_voltage_ok, // Control supply established
  output logic [4:0] term_out, // Transistor outputs
  output logic relay_contact_a, // Relay contact closed
  output logic fault_relay_drive, // Fault relay energised
  output logic wear_warning, // Component wear warning
  output logic irq // Level interrupt
);
  localparam logic [31:0] LIMIT_TARGET = 32'(LIMIT_CYCLES);
  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  // Pick one flag by selection code
  function automatic logic select_signal(input logic [5:0] code,
                                         input status_out_pkg::flags_s f,
                                         input status_out_pkg::drive_in_s d);
    logic v;
    v = 1'b0;
    case (code)
      status_out_pkg::SEL_RUN: v = d.running;
      status_out_pkg::SEL_ARRIVAL: v = f.arrival;
      status_out_pkg::SEL_LEVEL: v = f.level;
      status_out_pkg::SEL_OVERLOAD1: v = d.overload_warning_first;
      status_out_pkg::SEL_READY: v = d.ready;
      status_out_pkg::SEL_WEAR: v = f.wear;
      status_out_pkg::SEL_LEVEL2: v = f.level2;
      status_out_pkg::SEL_CURRENT2: v = f.current2;
      status_out_pkg::SEL_LOOP_LOSS: v = f.loop_loss;
      status_out_pkg::SEL_LIMIT_DELAY: v = f.limit_delay;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // Clamp a written setting to its top value
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] top);
    return (v > top) ? top : v;
  endfunction

  // Merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [3:0] ctrl_r, ctrl_nxt;
  logic [15:0] band_r, band_nxt, level_r, level_nxt, hyst_r, hyst_nxt;
  logic [15:0] level2_r, level2_nxt, cur_level_r, cur_level_nxt;
  logic [15:0] cur_timer_r, cur_timer_nxt, cap_ref_r, cap_ref_nxt;
  logic [29:0] term_sel_r, term_sel_nxt;
  logic [6:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] ms_cnt_r, ms_cnt_nxt;
  logic ms_tick_r, ms_tick_nxt;
  status_out_pkg::flags_s flags_r, flags_nxt;
  logic [4:0] term_r, term_nxt;
  logic relay_r, relay_nxt, fault_r, fault_nxt, irq_r, irq_nxt;
  logic [15:0] board_hours, fan_hours;
  logic current2_hit, limit_hit;
  logic bus_req, wr, rd;
  logic [31:0] wmerge;
  logic [15:0] level_top;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = bus_req && wb_we_i;
  assign rd = bus_req && !wb_we_i;

  // Millisecond enable divider
  always_comb begin
    ms_tick_nxt = (ms_cnt_r == MS_LAST);
    ms_cnt_nxt = ms_tick_nxt ? '0 : ms_cnt_r + 32'h00000001;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
      ms_tick_r <= ms_tick_nxt;
    end
  end

  hour_meter #(.TICKS_PER_HOUR(HOUR_MS)) u_board_hours (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(ms_tick_r),
    .active(1'b1),
    .hours(board_hours)
  );

  hour_meter #(.TICKS_PER_HOUR(HOUR_MS)) u_fan_hours (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(ms_tick_r),
    .active(drive_in.fan_running),
    .hours(fan_hours)
  );

  hold_timer u_current2 (
    .sys_clk(sys_clk),
    .reset(reset),
    .cond(drive_in.out_current > cur_level_r),
    .step(ms_tick_r),
    .target({16'h0000, cur_timer_r}),
    .expired(current2_hit)
  );

  // limiting delay, counted in cycles so 20 ms is never short
  hold_timer u_limit_delay (
    .sys_clk(sys_clk),
    .reset(reset),
    .cond(drive_in.torque_limiting || drive_in.regen_avoiding || drive_in.current_limiting),
    .step(1'b1),
    .target(LIMIT_TARGET),
    .expired(limit_hit)
  );

  // Detector flags
  always_comb begin
    logic [16:0] up, down, lvl2_floor;
    logic [31:0] meas, refv;
    flags_nxt = flags_r;
    up = {1'b0, drive_in.set_freq} + {1'b0, band_r};
    down = {1'b0, drive_in.set_freq} - {1'b0, band_r};
    meas = drive_in.main_cap_wear_data * {8'h00, status_out_pkg::CAP_RATIO_DEN};
    refv = cap_ref_r * {8'h00, status_out_pkg::CAP_RATIO_NUM};
    lvl2_floor = {1'b0, drive_in.out_freq} + {1'b0, hyst_r};
    // arrival band, underflow of the lower edge treated as zero
    flags_nxt.arrival = ({1'b0, drive_in.out_freq} <= up) &&
                        (down[16] || {1'b0, drive_in.out_freq} >= down);
    if (drive_in.out_freq > level_r) begin
      flags_nxt.level = 1'b1;
    end else if ({1'b0, drive_in.out_freq} + {1'b0, hyst_r} < {1'b0, level_r}) begin
      flags_nxt.level = 1'b0;
    end
    if (drive_in.out_freq > level2_r) begin
      flags_nxt.level2 = 1'b1;
    end else if (lvl2_floor < {1'b0, level2_r}) begin
      flags_nxt.level2 = 1'b0;
    end
    flags_nxt.current2 = current2_hit;
    flags_nxt.loop_loss = drive_in.analog_current_input < status_out_pkg::LOOP_LOSS_UA;
    flags_nxt.limit_delay = limit_hit;
    // any wear source raises the warning
    // capacitor at 85 percent or less
    // broken stirring fan on large units
    flags_nxt.wear = (ctrl_r[status_out_pkg::CTRL_CAP_JUDGE] && cap_ref_r != 16'h0000 &&
                      meas <= refv) ||
                     (board_hours >= status_out_pkg::BOARD_CAP_HOURS) ||
                     (fan_hours >= status_out_pkg::FAN_HOURS) ||
                     (ctrl_r[status_out_pkg::CTRL_BIG_UNIT] && drive_in.stir_fan_status);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Output terminals, relay and interrupt line
  always_comb begin
    logic y5;
    for (int t = 0; t < status_out_pkg::TERMS; t++) begin
      term_nxt[t] = select_signal(term_sel_r[6*t +: 6], flags_r, drive_in);
    end
    y5 = term_nxt[status_out_pkg::TERMS-1];
    // inverted contact only once control voltage is up
    relay_nxt = ctrl_voltage_ok && (y5 ^ ctrl_r[status_out_pkg::CTRL_POLARITY]);
    // wear never reaches the fault relay
    fault_nxt = drive_in.fault;
    irq_nxt = |(irq_stat_r & irq_mask_r);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      term_r <= '0;
      relay_r <= 1'b0;
      fault_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      term_r <= term_nxt;
      relay_r <= relay_nxt;
      fault_r <= fault_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Register file; band, levels and hysteresis are clamped on write, but a later model change does not re-clamp the levels
  always_comb begin
    logic [6:0] rise;
    ctrl_nxt = ctrl_r;
    band_nxt = band_r;
    level_nxt = level_r;
    hyst_nxt = hyst_r;
    level2_nxt = level2_r;
    cur_level_nxt = cur_level_r;
    cur_timer_nxt = cur_timer_r;
    cap_ref_nxt = cap_ref_r;
    term_sel_nxt = term_sel_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    dat_nxt = '0;
    ack_nxt = bus_req;
    wmerge = '0;
    level_top = ctrl_r[status_out_pkg::CTRL_FAN_PUMP] ? status_out_pkg::LEVEL_MAX_FAN_PUMP :
                status_out_pkg::LEVEL_MAX_GENERAL;
    rise = flags_nxt & ~flags_r;
    case (wb_adr_i)
      status_out_pkg::OFS_CTRL: wmerge = merge({28'h0, ctrl_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_ARRIVAL_BAND: wmerge = merge({16'h0, band_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_LEVEL: wmerge = merge({16'h0, level_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_HYST: wmerge = merge({16'h0, hyst_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_LEVEL2: wmerge = merge({16'h0, level2_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_CUR_LEVEL: wmerge = merge({16'h0, cur_level_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_CUR_TIMER: wmerge = merge({16'h0, cur_timer_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_CAP_REF: wmerge = merge({16'h0, cap_ref_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_TERM_SEL: wmerge = merge({2'h0, term_sel_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_IRQ_MASK: wmerge = merge({25'h0, irq_mask_r}, wb_dat_i, wb_sel_i);
      status_out_pkg::OFS_IRQ_STAT: wmerge = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      default: wmerge = '0;
    endcase
    if (wr) begin
      case (wb_adr_i)
        status_out_pkg::OFS_CTRL: ctrl_nxt = wmerge[3:0];
        status_out_pkg::OFS_ARRIVAL_BAND: band_nxt = clamp(wmerge[15:0],
                                                           status_out_pkg::ARRIVAL_BAND_MAX);
        status_out_pkg::OFS_LEVEL: level_nxt = clamp(wmerge[15:0], level_top);
        status_out_pkg::OFS_HYST: hyst_nxt = clamp(wmerge[15:0], status_out_pkg::HYST_MAX);
        status_out_pkg::OFS_LEVEL2: level2_nxt = clamp(wmerge[15:0], level_top);
        status_out_pkg::OFS_CUR_LEVEL: cur_level_nxt = wmerge[15:0];
        status_out_pkg::OFS_CUR_TIMER: cur_timer_nxt = wmerge[15:0];
        status_out_pkg::OFS_CAP_REF: cap_ref_nxt = wmerge[15:0];
        status_out_pkg::OFS_TERM_SEL: term_sel_nxt = wmerge[29:0];
        status_out_pkg::OFS_IRQ_MASK: irq_mask_nxt = wmerge[6:0];
        status_out_pkg::OFS_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~wmerge[6:0];
        default: irq_stat_nxt = irq_stat_r;
      endcase
    end
    // New events win over a same-cycle clear
    irq_stat_nxt = irq_stat_nxt | rise;
    if (rd) begin
      case (wb_adr_i)
        status_out_pkg::OFS_CTRL: dat_nxt = {28'h0, ctrl_r};
        status_out_pkg::OFS_ARRIVAL_BAND: dat_nxt = {16'h0, band_r};
        status_out_pkg::OFS_LEVEL: dat_nxt = {16'h0, level_r};
        status_out_pkg::OFS_HYST: dat_nxt = {16'h0, hyst_r};
        status_out_pkg::OFS_LEVEL2: dat_nxt = {16'h0, level2_r};
        status_out_pkg::OFS_CUR_LEVEL: dat_nxt = {16'h0, cur_level_r};
        status_out_pkg::OFS_CUR_TIMER: dat_nxt = {16'h0, cur_timer_r};
        status_out_pkg::OFS_CAP_REF: dat_nxt = {16'h0, cap_ref_r};
        status_out_pkg::OFS_TERM_SEL: dat_nxt = {2'h0, term_sel_r};
        status_out_pkg::OFS_STATUS: dat_nxt = {25'h0, flags_r};
        status_out_pkg::OFS_IRQ_STAT: dat_nxt = {25'h0, irq_stat_r};
        status_out_pkg::OFS_IRQ_MASK: dat_nxt = {25'h0, irq_mask_r};
        status_out_pkg::OFS_BOARD_HOURS: dat_nxt = {16'h0, board_hours};
        status_out_pkg::OFS_FAN_HOURS: dat_nxt = {16'h0, fan_hours};
        default: dat_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_r <= status_out_pkg::CTRL_RESET;
      band_r <= status_out_pkg::SETTING_RESET;
      level_r <= status_out_pkg::SETTING_RESET;
      hyst_r <= status_out_pkg::SETTING_RESET;
      level2_r <= status_out_pkg::SETTING_RESET;
      cur_level_r <= status_out_pkg::SETTING_RESET;
      cur_timer_r <= status_out_pkg::SETTING_RESET;
      cap_ref_r <= status_out_pkg::SETTING_RESET;
      term_sel_r <= status_out_pkg::TERM_SEL_RESET;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      dat_r <= '0;
      ack_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      band_r <= band_nxt;
      level_r <= level_nxt;
      hyst_r <= hyst_nxt;
      level2_r <= level2_nxt;
      cur_level_r <= cur_level_nxt;
      cur_timer_r <= cur_timer_nxt;
      cap_ref_r <= cap_ref_nxt;
      term_sel_r <= term_sel_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign term_out = term_r;
  assign relay_contact_a = relay_r;
  assign fault_relay_drive = fault_r;
  assign wear_warning = flags_r.wear;
  assign irq = irq_r;
endmodule // drive_status_output_logic
`default_nettype wire

// *** shared/status_out_pkg.sv ***
package status_out_pkg;

  // Wishbone word offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ARRIVAL_BAND = 8'h04;
  localparam logic [7:0] OFS_LEVEL = 8'h08;
  localparam logic [7:0] OFS_HYST = 8'h0C;
  localparam logic [7:0] OFS_LEVEL2 = 8'h10;
  localparam logic [7:0] OFS_CUR_LEVEL = 8'h14;
  localparam logic [7:0] OFS_CUR_TIMER = 8'h18;
  localparam logic [7:0] OFS_CAP_REF = 8'h1C;
  localparam logic [7:0] OFS_TERM_SEL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFS_BOARD_HOURS = 8'h30;
  localparam logic [7:0] OFS_FAN_HOURS = 8'h34;

  // Control register fields
  localparam int CTRL_POLARITY = 0;
  localparam int CTRL_BIG_UNIT = 1;
  localparam int CTRL_FAN_PUMP = 2;
  localparam int CTRL_CAP_JUDGE = 3;
  localparam logic [3:0] CTRL_RESET = 4'h8;

  // Frequencies in 0.1 Hz steps
  localparam logic [15:0] ARRIVAL_BAND_MAX = 16'h0064;
  localparam logic [15:0] LEVEL_MAX_GENERAL = 16'h0FA0;
  localparam logic [15:0] LEVEL_MAX_FAN_PUMP = 16'h04B0;
  localparam logic [15:0] HYST_MAX = 16'h012C;
  localparam logic [15:0] SETTING_RESET = 16'h0000;

  // Wear judgement: 85 percent as 17/20, hours, loop current in uA
  localparam logic [7:0] CAP_RATIO_NUM = 8'h11;
  localparam logic [7:0] CAP_RATIO_DEN = 8'h14;
  localparam logic [15:0] BOARD_CAP_HOURS = 16'hEE48;
  localparam logic [15:0] FAN_HOURS = 16'h61A8;
  localparam logic [15:0] LOOP_LOSS_UA = 16'h07D0;

  // Timing
  localparam longint CLK_HZ = 200_000_000;
  localparam int LIMIT_DELAY_MS = 20;
  localparam longint LIMIT_DELAY_CYCLES = CLK_HZ * LIMIT_DELAY_MS / 1000;
  localparam longint CYCLES_PER_MS = CLK_HZ / 1000;
  localparam longint MS_PER_HOUR = 3_600_000;

  // Output selection codes
  localparam logic [5:0] SEL_RUN = 6'h00;
  localparam logic [5:0] SEL_ARRIVAL = 6'h01;
  localparam logic [5:0] SEL_LEVEL = 6'h02;
  localparam logic [5:0] SEL_OVERLOAD1 = 6'h07;
  localparam logic [5:0] SEL_READY = 6'h0A;
  localparam logic [5:0] SEL_WEAR = 6'h1E;
  localparam logic [5:0] SEL_LEVEL2 = 6'h1F;
  localparam logic [5:0] SEL_CURRENT2 = 6'h20;
  localparam logic [5:0] SEL_LOOP_LOSS = 6'h21;
  localparam logic [5:0] SEL_LIMIT_DELAY = 6'h22;
  localparam int TERMS = 5;
  localparam logic [29:0] TERM_SEL_RESET = {SEL_READY, SEL_OVERLOAD1, SEL_LEVEL, SEL_ARRIVAL,
                                            SEL_RUN};

  // Drive quantities presented to the block each cycle
  typedef struct packed {
    logic [15:0] out_freq;      // 0.1 Hz
    logic [15:0] set_freq;      // 0.1 Hz
    logic [15:0] out_current;
    logic [15:0] main_cap_wear_data;
    logic [15:0] analog_current_input; // uA
    logic torque_limiting;
    logic regen_avoiding;
    logic current_limiting;
    logic running;
    logic fan_running;
    logic stir_fan_status;      // 1 = broken
    logic overload_warning_first;
    logic ready;
    logic fault;
  } drive_in_s;

  // Internal status flags, also the live status register layout
  typedef struct packed {
    logic limit_delay;
    logic loop_loss;
    logic current2;
    logic level2;
    logic level;
    logic arrival;
    logic wear;
  } flags_s;

endpackage

// *** logic/hold_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module hold_timer (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic cond, // Condition being timed
  input wire logic step, // Count enable
  input wire logic [31:0] target, // Steps needed
  output logic expired // Condition held long enough
);
  logic [31:0] cnt_r, cnt_nxt;
  logic expired_r, expired_nxt;

  // Any drop of the condition restarts from zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (!cond) begin
      cnt_nxt = '0;
    end else if (step && cnt_r < target) begin
      cnt_nxt = cnt_r + 32'h00000001;
    end
    expired_nxt = cond && (cnt_nxt >= target);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_r <= '0;
      expired_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;
endmodule // hold_timer
`default_nettype wire

// *** logic/hour_meter.sv ***
`timescale 1ns/100ps
`default_nettype none
module hour_meter #(
  parameter longint TICKS_PER_HOUR = 3_600_000
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic tick, // Millisecond enable
  input wire logic active, // Time accumulates while high
  output logic [15:0] hours // Whole hours, saturating
);
  localparam logic [31:0] LAST = 32'(TICKS_PER_HOUR - 1);
  logic [31:0] sub_r, sub_nxt;
  logic [15:0] hours_r, hours_nxt;

  // Saturate rather than wrap so wear never clears itself
  always_comb begin
    sub_nxt = sub_r;
    hours_nxt = hours_r;
    if (tick && active && hours_r != 16'hFFFF) begin
      if (sub_r >= LAST) begin
        sub_nxt = '0;
        hours_nxt = hours_r + 16'h0001;
      end else begin
        sub_nxt = sub_r + 32'h00000001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sub_r <= '0;
      hours_r <= '0;
    end else begin
      sub_r <= sub_nxt;
      hours_r <= hours_nxt;
    end
  end

  assign hours = hours_r;
endmodule // hour_meter
`default_nettype wire

// *** sim/drive_status_output_logic_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module status_props (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire status_out_pkg::drive_in_s drive_in, // Quantities
  input wire logic ctrl_voltage_ok, // Supply ok
  input wire logic [4:0] term_out, // Terminals
  input wire logic relay_contact_a, // Relay
  input wire logic fault_relay_drive, // Fault relay
  input wire logic wear_warning, // Wear
  input wire logic irq // Interrupt
);
  // One domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_write: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("read data on write ack");
  a_relay_supply: assert property (!ctrl_voltage_ok [*3] |-> !relay_contact_a)
    else $error("relay closed without control supply");
  a_fault_quiet: assert property (!drive_in.fault [*3] |-> !fault_relay_drive)
    else $error("fault relay energised without fault");
  a_out_reset: assert property ($fell(reset) |-> term_out == 5'h00 && !irq && !wear_warning)
    else $error("outputs not cleared by reset");
  // Main scenarios reached
  c_wear: cover property ($rose(wear_warning));
  c_relay: cover property ($rose(relay_contact_a));
  c_irq: cover property ($rose(irq));
endmodule // status_props
bind drive_status_output_logic status_props u_status_props (.sys_clk, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .drive_in, .ctrl_voltage_ok, .term_out,
  .relay_contact_a, .fault_relay_drive, .wear_warning, .irq);
`default_nettype wire

// *** sim/status_reader.sv ***
`timescale 1ns/100ps
`default_nettype none
module status_reader (
  input wire logic sys_clk, // Clock
  input wire logic [4:0] term_out, // Terminals
  input wire logic relay_contact_a, // Relay
  output logic [5:0] seen_r // Latched outputs
);
  // Equipment scans its inputs once a clock, so it lags the block by one edge
  always_ff @(posedge sys_clk) begin
    seen_r <= {relay_contact_a, term_out};
  end
endmodule // status_reader
`default_nettype wire

// *** sim/drive_status_output_logic_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module drive_status_output_logic_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic cv = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, relay, fault_rly, wear, irq;
  logic [4:0] term;
  logic [5:0] seen;
  status_out_pkg::drive_in_s di = '0;
  int bad_count = 0;
  int tests_run = 0;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  // Short counts keep the limiting and timer cases brief
  drive_status_output_logic #(.LIMIT_CYCLES(40), .MS_CYCLES(4), .HOUR_MS(2))
    u_drive_status_output_logic (.sys_clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .drive_in(di), .ctrl_voltage_ok(cv), .term_out(term),
    .relay_contact_a(relay), .fault_relay_drive(fault_rly), .wear_warning(wear), .irq);
  status_reader u_status_reader (.sys_clk, .term_out(term), .relay_contact_a(relay),
    .seen_r(seen));
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Wait for ack however long it takes; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    bus(1'b1, a, d);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Live status bit, read after the flag pipeline settles
  task automatic sb(input int i, input logic e);
    tk(4);
    bus(1'b0, status_out_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, q[i]}, {31'h0, e});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    tk(20);
    reset <= 1'b0;
    cv <= 1'b1;
    tk(1);
    bus(1'b0, status_out_pkg::OFS_TERM_SEL, 32'h0);
    chk(q, {2'h0, status_out_pkg::TERM_SEL_RESET});
    di.running <= 1'b1;
    di.ready <= 1'b1;
    tk(4);
    chk(seen, 6'h33);
    wc(status_out_pkg::OFS_CTRL, 32'h9, 32'h9);
    tk(4);
    chk(seen[5], 1'b0);
    di.ready <= 1'b0;
    cv <= 1'b0;
    tk(4);
    chk(seen[5], 1'b0);
    cv <= 1'b1;
    tk(4);
    chk(seen[5], 1'b1);
    $display("test outputs done");
    wc(status_out_pkg::OFS_ARRIVAL_BAND, 32'hFFFF, 32'h64);
    wc(status_out_pkg::OFS_HYST, 32'hFFFF, 32'h12C);
    wc(status_out_pkg::OFS_CTRL, 32'hC, 32'hC);
    wc(status_out_pkg::OFS_LEVEL, 32'hFFFF, 32'h4B0);
    wc(status_out_pkg::OFS_CTRL, 32'h8, 32'h8);
    wc(status_out_pkg::OFS_LEVEL, 32'hFFFF, 32'hFA0);
    wc(status_out_pkg::OFS_LEVEL, 32'h64, 32'h64);
    wc(status_out_pkg::OFS_HYST, 32'h14, 32'h14);
    wc(status_out_pkg::OFS_LEVEL2, 32'hC8, 32'hC8);
    di.out_freq <= 16'h65;
    sb(2, 1'b1);
    sb(3, 1'b0);
    di.out_freq <= 16'h50;
    sb(2, 1'b1);
    di.out_freq <= 16'h4F;
    sb(2, 1'b0);
    di.out_freq <= 16'hC9;
    sb(3, 1'b1);
    di.out_freq <= 16'hB3;
    sb(3, 1'b0);
    $display("test levels done");
    wc(status_out_pkg::OFS_IRQ_MASK, 32'h7F, 32'h7F);
    bus(1'b1, status_out_pkg::OFS_IRQ_STAT, 32'h7F);
    di.analog_current_input <= status_out_pkg::LOOP_LOSS_UA;
    di.out_freq <= 16'h1F4;
    di.set_freq <= 16'h1F4;
    sb(1, 1'b1);
    bus(1'b1, status_out_pkg::OFS_IRQ_STAT, 32'h7F);
    tk(4);
    chk(irq, 1'b0);
    di.out_freq <= 16'h258;
    // Loop loss rising gives the unmasked interrupt a fresh event
    di.analog_current_input <= 16'h7CF;
    sb(1, 1'b1);
    chk(irq, 1'b1);
    wc(status_out_pkg::OFS_IRQ_MASK, 32'h0, 32'h0);
    tk(4);
    chk(irq, 1'b0);
    di.out_freq <= 16'h259;
    sb(1, 1'b0);
    di.analog_current_input <= 16'h7CF;
    sb(5, 1'b1);
    $display("test arrival and irq done");
    di.torque_limiting <= 1'b1;
    tk(30);
    di.torque_limiting <= 1'b0;
    tk(1);
    di.torque_limiting <= 1'b1;
    tk(30);
    di.torque_limiting <= 1'b0;
    sb(6, 1'b0);
    for (int i = 0; i < 3; i++) begin
      {di.torque_limiting, di.regen_avoiding, di.current_limiting} <= 3'h1 << i;
      tk(45);
      sb(6, 1'b1);
      {di.torque_limiting, di.regen_avoiding, di.current_limiting} <= 3'h0;
      sb(6, 1'b0);
    end
    wc(status_out_pkg::OFS_CUR_LEVEL, 32'h64, 32'h64);
    wc(status_out_pkg::OFS_CUR_TIMER, 32'h2, 32'h2);
    di.out_current <= 16'hC8;
    sb(4, 1'b0);
    di.out_current <= 16'h64;
    tk(1);
    di.out_current <= 16'hC8;
    sb(4, 1'b0);
    tk(16);
    sb(4, 1'b1);
    $display("test timed flags done");
    wc(status_out_pkg::OFS_CAP_REF, 32'h64, 32'h64);
    di.main_cap_wear_data <= 16'h55;
    tk(4);
    chk(wear, 1'b1);
    chk(fault_rly, 1'b0);
    di.main_cap_wear_data <= 16'h56;
    tk(4);
    chk(wear, 1'b0);
    di.stir_fan_status <= 1'b1;
    wc(status_out_pkg::OFS_CTRL, 32'hA, 32'hA);
    tk(4);
    chk(wear, 1'b1);
    wc(status_out_pkg::OFS_CTRL, 32'h8, 32'h8);
    tk(4);
    chk(wear, 1'b0);
    bus(1'b1, 8'h3C, 32'hFFFF);
    bus(1'b0, 8'h3C, 32'h0);
    chk(q, 32'h0);
    // Fan never ran, so its meter must still read zero
    bus(1'b0, status_out_pkg::OFS_FAN_HOURS, 32'h0);
    chk(q, 32'h0);
    $display("test wear and map done");
    test_done();
  end
endmodule // drive_status_output_logic_tb_top
`default_nettype wire
